// [rtl/irq_pkg.sv]
// constants, field layouts and carrier types of the eight-source interrupt priority unit
// assumes a single 40 MHz clock domain and an 8-bit special-register bus
package irq_pkg;

  localparam int NUM_SRC = 8;
  localparam int NUM_LEVEL = 4;
  localparam int NUM_MODULE = 5;

  // register offsets on the byte bus
  localparam logic [7:0] ADDR_ENABLE_MAIN = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_HIGH_MAIN = 8'hB7;
  localparam logic [7:0] ADDR_PRIO_LOW_MAIN = 8'hB8;
  localparam logic [7:0] ADDR_ENABLE_AUX = 8'hE8;
  localparam logic [7:0] ADDR_PRIO_HIGH_AUX = 8'hF7;
  localparam logic [7:0] ADDR_PRIO_LOW_AUX = 8'hF8;
  localparam logic [7:0] ADDR_MODULE_FLAGS = 8'hC9;
  localparam logic [7:0] ADDR_SERVICE_STATUS = 8'hCA;

  // bit space: base is the bit address with the low three bits dropped
  localparam logic [7:0] BIT_BASE_MASK = 8'hF8;

  localparam logic [7:0] REG_RESET = 8'h00;

  // implemented bits of each register; the rest read as zero
  localparam logic [7:0] MASK_ENABLE_MAIN = 8'hFF;
  localparam logic [7:0] MASK_PRIO_MAIN = 8'h7F;
  localparam logic [7:0] MASK_ENABLE_AUX = 8'h08;
  localparam logic [7:0] MASK_PRIO_AUX = 8'h10;
  localparam logic [7:0] MASK_MODULE_FLAGS = 8'h1F;

  // field positions
  localparam int POS_GLOBAL_ENABLE = 7;
  localparam int POS_COUNTER_ARRAY = 6;
  localparam int POS_TIMER2 = 5;
  localparam int POS_SERIAL = 4;
  localparam int POS_TIMER1 = 3;
  localparam int POS_EXT1 = 2;
  localparam int POS_TIMER0 = 1;
  localparam int POS_EXT0 = 0;
  localparam int POS_BROWNOUT_ENABLE = 3;
  localparam int POS_BROWNOUT_PRIO = 4;

  // source index equals service order at equal level, 0 served first
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_BROWNOUT = 3'h1;
  localparam logic [2:0] SRC_TIMER0 = 3'h2;
  localparam logic [2:0] SRC_EXT1 = 3'h3;
  localparam logic [2:0] SRC_TIMER1 = 3'h4;
  localparam logic [2:0] SRC_COUNTER_ARRAY = 3'h5;
  localparam logic [2:0] SRC_SERIAL = 3'h6;
  localparam logic [2:0] SRC_TIMER2 = 3'h7;

  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_BROWNOUT = 16'h004B;
  localparam logic [15:0] VEC_TIMER0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TIMER1 = 16'h001B;
  localparam logic [15:0] VEC_COUNTER_ARRAY = 16'h0033;
  localparam logic [15:0] VEC_SERIAL = 16'h0023;
  localparam logic [15:0] VEC_TIMER2 = 16'h002B;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b10
  } ctrl_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic val;
  } bit_req_t;

  typedef struct packed {
    logic ext0_request_flag;
    logic ext1_request_flag;
    logic ext0_level_mode;
    logic ext1_level_mode;
    logic brownout_detect;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer2_overflow_flag;
    logic timer2_external_flag;
    logic counter_array_overflow_flag;
    logic [NUM_MODULE-1:0] match_capture_event;
    logic [NUM_MODULE-1:0] module_irq_enable;
    logic serial_tx_done_flag;
    logic serial_rx_done_flag;
    logic sync_serial_done_flag;
  } src_flags_t;

  typedef struct packed {
    logic req;
    logic [1:0] level;
    logic [15:0] vector;
  } irq_offer_t;

endpackage : irq_pkg

// [rtl/irq_priority_resolver.sv]
// picks the winning pending source: highest level, then lowest index
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module irq_priority_resolver
  import irq_pkg::*;
(
  // candidates
  input wire logic [NUM_SRC-1:0] pending_i,
  input wire logic [NUM_SRC-1:0][1:0] level_i,
  // winner
  output logic win_valid_o,
  output logic [2:0] win_index_o,
  output logic [1:0] win_level_o
);

  logic [NUM_SRC-1:0] win;

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    logic beaten;
    always_comb begin
      beaten = 1'b0;
      for (int j = 0; j < NUM_SRC; j++) begin
        if (pending_i[j] && (level_i[j] > level_i[i])) begin
          beaten = 1'b1;
        end
        if (pending_i[j] && (level_i[j] == level_i[i]) && (j < i)) begin
          beaten = 1'b1;
        end
      end
    end
    assign win[i] = pending_i[i] & ~beaten;
  end

  always_comb begin
    win_valid_o = |win;
    win_index_o = 3'h0;
    win_level_o = 2'h0;
    for (int k = 0; k < NUM_SRC; k++) begin
      if (win[k]) begin
        win_index_o = k[2:0];
        win_level_o = level_i[k];
      end
    end
  end

endmodule : irq_priority_resolver

// [rtl/irq_priority_unit.sv]
// eight-source interrupt priority unit: enables, priorities, arbitration, vector offer
// assumes request flags synchronous to clock_i and a core that acks and returns by pulses
//
// Notes on behaviour
// - eight sources arbitrated over four levels
// - both serial ports share vector 0023H
// - vectors 0003H, 004BH, 000BH for first three
// - vectors 0013H, 001BH, 0033H for next three
// - counter array vector 0033H from its flags
// - equal level served in fixed polling order
// - global enable bit 7 gates all servicing
// - main enable register at A8H, seven sources
// - aux enable E8H bit 3 for brown-out
// - priority low bits at B8H
// - priority high bits at B7H, same layout
// - brown-out priority low at F8H bit 4
// - all enable and priority registers reset 00H
// - B7H and F7H byte only; others also bit access
// - brown-out priority high at F7H bit 4
// - module flags set by hardware, software clears
// - power-down wakes only on enabled level inputs
`timescale 1ns/1ps
module irq_priority_unit
  import irq_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // byte register bus
  input wire reg_req_t reg_req_i,
  output logic [7:0] rdata_o,
  // single-bit register access
  input wire bit_req_t bit_req_i,
  output logic bit_rdata_o,
  // request sources
  input wire src_flags_t src_i,
  input wire logic power_down_i,
  // processor core handshake
  input wire logic irq_ack_i,
  input wire logic irq_return_i,
  output irq_offer_t offer_o,
  output logic wake_o
);

  typedef struct packed {
    logic [7:0] enable_main;
    logic [7:0] prio_high_main;
    logic [7:0] prio_low_main;
    logic [7:0] enable_aux;
    logic [7:0] prio_high_aux;
    logic [7:0] prio_low_aux;
    logic [NUM_MODULE-1:0] module_flags;
    logic [NUM_LEVEL-1:0] in_service;
    ctrl_state_t fsm;
    irq_offer_t offer;
    logic wake;
    logic [7:0] rdata;
    logic bit_rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  // per-source views, indexed in polling order
  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] src_enable;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0][1:0] src_level;
  logic [NUM_SRC-1:0] prio_h;
  logic [NUM_SRC-1:0] prio_l;
  logic [NUM_SRC-1:0] pd_mask;

  // arbitration result and the gate in front of the offer
  logic win_valid;
  logic [2:0] win_index;
  logic [1:0] win_level;
  logic global_enable;
  logic any_service;
  logic [1:0] service_level;
  logic may_offer;
  logic [15:0] win_vector;

  // fixed map; no vector register, so software cannot move a handler
  function automatic logic [15:0] vector_of(input logic [2:0] idx);
    logic [15:0] v;
    v = VEC_EXT0;
    case (idx)
      SRC_EXT0: v = VEC_EXT0;
      SRC_BROWNOUT: v = VEC_BROWNOUT;
      SRC_TIMER0: v = VEC_TIMER0;
      SRC_EXT1: v = VEC_EXT1;
      SRC_TIMER1: v = VEC_TIMER1;
      SRC_COUNTER_ARRAY: v = VEC_COUNTER_ARRAY;
      SRC_SERIAL: v = VEC_SERIAL;
      SRC_TIMER2: v = VEC_TIMER2;
      default: v = VEC_EXT0;
    endcase
    return v;
  endfunction : vector_of

  // replace one bit of a register image
  function automatic logic [7:0] put_bit(input logic [7:0] old, input logic [2:0] pos,
                                         input logic val);
    logic [7:0] r;
    r = old;
    r[pos] = val;
    return r;
  endfunction : put_bit

  // source view of the registers, in polling order
  always_comb begin
    raw_req = '0;
    raw_req[SRC_EXT0] = src_i.ext0_request_flag;
    raw_req[SRC_BROWNOUT] = src_i.brownout_detect;
    raw_req[SRC_TIMER0] = src_i.timer0_overflow_flag;
    raw_req[SRC_EXT1] = src_i.ext1_request_flag;
    raw_req[SRC_TIMER1] = src_i.timer1_overflow_flag;
    raw_req[SRC_COUNTER_ARRAY] = src_i.counter_array_overflow_flag |
      (|(cur.module_flags & src_i.module_irq_enable));
    raw_req[SRC_SERIAL] = src_i.serial_tx_done_flag | src_i.serial_rx_done_flag |
      src_i.sync_serial_done_flag;
    raw_req[SRC_TIMER2] = src_i.timer2_overflow_flag | src_i.timer2_external_flag;

    src_enable = '0;
    src_enable[SRC_EXT0] = cur.enable_main[POS_EXT0];
    src_enable[SRC_BROWNOUT] = cur.enable_aux[POS_BROWNOUT_ENABLE];
    src_enable[SRC_TIMER0] = cur.enable_main[POS_TIMER0];
    src_enable[SRC_EXT1] = cur.enable_main[POS_EXT1];
    src_enable[SRC_TIMER1] = cur.enable_main[POS_TIMER1];
    src_enable[SRC_COUNTER_ARRAY] = cur.enable_main[POS_COUNTER_ARRAY];
    src_enable[SRC_SERIAL] = cur.enable_main[POS_SERIAL];
    src_enable[SRC_TIMER2] = cur.enable_main[POS_TIMER2];

    prio_l = '0;
    prio_l[SRC_EXT0] = cur.prio_low_main[POS_EXT0];
    prio_l[SRC_BROWNOUT] = cur.prio_low_aux[POS_BROWNOUT_PRIO];
    prio_l[SRC_TIMER0] = cur.prio_low_main[POS_TIMER0];
    prio_l[SRC_EXT1] = cur.prio_low_main[POS_EXT1];
    prio_l[SRC_TIMER1] = cur.prio_low_main[POS_TIMER1];
    prio_l[SRC_COUNTER_ARRAY] = cur.prio_low_main[POS_COUNTER_ARRAY];
    prio_l[SRC_SERIAL] = cur.prio_low_main[POS_SERIAL];
    prio_l[SRC_TIMER2] = cur.prio_low_main[POS_TIMER2];

    prio_h = '0;
    prio_h[SRC_EXT0] = cur.prio_high_main[POS_EXT0];
    prio_h[SRC_BROWNOUT] = cur.prio_high_aux[POS_BROWNOUT_PRIO];
    prio_h[SRC_TIMER0] = cur.prio_high_main[POS_TIMER0];
    prio_h[SRC_EXT1] = cur.prio_high_main[POS_EXT1];
    prio_h[SRC_TIMER1] = cur.prio_high_main[POS_TIMER1];
    prio_h[SRC_COUNTER_ARRAY] = cur.prio_high_main[POS_COUNTER_ARRAY];
    prio_h[SRC_SERIAL] = cur.prio_high_main[POS_SERIAL];
    prio_h[SRC_TIMER2] = cur.prio_high_main[POS_TIMER2];

    // with the clock stopped only level-mode external inputs can be seen
    pd_mask = '1;
    if (power_down_i) begin
      pd_mask = '0;
      pd_mask[SRC_EXT0] = src_i.ext0_level_mode;
      pd_mask[SRC_EXT1] = src_i.ext1_level_mode;
    end
  end

  // two-bit level, high bit on top
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_level
    assign src_level[s] = {prio_h[s], prio_l[s]};
  end

  // a source counts only when flagged, enabled and visible in power-down
  assign pending = raw_req & src_enable & pd_mask;
  assign global_enable = cur.enable_main[POS_GLOBAL_ENABLE];

  // combinational winner; the offer state below registers it
  irq_priority_resolver u_resolver (
    .pending_i(pending),
    .level_i(src_level),
    .win_valid_o(win_valid),
    .win_index_o(win_index),
    .win_level_o(win_level)
  );

  // highest level currently in service
  // several levels can be set at once while routines nest
  always_comb begin
    any_service = |cur.in_service;
    service_level = 2'h0;
    for (int l = 0; l < NUM_LEVEL; l++) begin
      if (cur.in_service[l]) begin
        service_level = l[1:0];
      end
    end
  end

  // equal level never preempts, so a routine is not re-entered by its peers
  assign may_offer = win_valid && global_enable &&
    (!any_service || (win_level > service_level));
  assign win_vector = vector_of(win_index);

  always_comb begin
    logic [7:0] bit_base;
    logic [2:0] bit_pos;
    logic [7:0] rd_word;
    logic [7:0] bit_word;
    logic [NUM_LEVEL-1:0] svc;
    bit_base = bit_req_i.addr & BIT_BASE_MASK;
    bit_pos = bit_req_i.addr[2:0];
    rd_word = 8'h00;
    bit_word = 8'h00;
    svc = '0;
    next_cur = cur;

    // byte writes; unused bits are dropped so they always read zero
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_ENABLE_MAIN: next_cur.enable_main = reg_req_i.wdata & MASK_ENABLE_MAIN;
        ADDR_PRIO_HIGH_MAIN: next_cur.prio_high_main = reg_req_i.wdata & MASK_PRIO_MAIN;
        ADDR_PRIO_LOW_MAIN: next_cur.prio_low_main = reg_req_i.wdata & MASK_PRIO_MAIN;
        ADDR_ENABLE_AUX: next_cur.enable_aux = reg_req_i.wdata & MASK_ENABLE_AUX;
        ADDR_PRIO_HIGH_AUX: next_cur.prio_high_aux = reg_req_i.wdata & MASK_PRIO_AUX;
        ADDR_PRIO_LOW_AUX: next_cur.prio_low_aux = reg_req_i.wdata & MASK_PRIO_AUX;
        ADDR_MODULE_FLAGS: next_cur.module_flags = reg_req_i.wdata[NUM_MODULE-1:0];
        // status and unmapped addresses land here and change nothing
        default: next_cur.enable_main = cur.enable_main;
      endcase
    end

    // bit writes reach only the four bit-addressable registers
    // applied after the byte write and built from the old value, so a same-cycle pair keeps only the bit write
    if (bit_req_i.wr) begin
      case (bit_base)
        ADDR_ENABLE_MAIN: next_cur.enable_main =
          put_bit(cur.enable_main, bit_pos, bit_req_i.val) & MASK_ENABLE_MAIN;
        ADDR_PRIO_LOW_MAIN: next_cur.prio_low_main =
          put_bit(cur.prio_low_main, bit_pos, bit_req_i.val) & MASK_PRIO_MAIN;
        ADDR_ENABLE_AUX: next_cur.enable_aux =
          put_bit(cur.enable_aux, bit_pos, bit_req_i.val) & MASK_ENABLE_AUX;
        ADDR_PRIO_LOW_AUX: next_cur.prio_low_aux =
          put_bit(cur.prio_low_aux, bit_pos, bit_req_i.val) & MASK_PRIO_AUX;
        default: next_cur.enable_aux = next_cur.enable_aux;
      endcase
    end

    // hardware set wins over a software clear in the same cycle
    next_cur.module_flags = next_cur.module_flags | src_i.match_capture_event;

    // read data, one cycle after the strobe, zero when unmapped
    // forced to zero outside its slot so several slaves can be or-ed
    case (reg_req_i.addr)
      ADDR_ENABLE_MAIN: rd_word = cur.enable_main;
      ADDR_PRIO_HIGH_MAIN: rd_word = cur.prio_high_main;
      ADDR_PRIO_LOW_MAIN: rd_word = cur.prio_low_main;
      ADDR_ENABLE_AUX: rd_word = cur.enable_aux;
      ADDR_PRIO_HIGH_AUX: rd_word = cur.prio_high_aux;
      ADDR_PRIO_LOW_AUX: rd_word = cur.prio_low_aux;
      ADDR_MODULE_FLAGS: rd_word = {3'h0, cur.module_flags};
      ADDR_SERVICE_STATUS: rd_word = {cur.in_service, 4'h0} | {4'h0, cur.fsm, service_level};
      default: rd_word = 8'h00;
    endcase
    next_cur.rdata = reg_req_i.rd ? rd_word : 8'h00;

    case (bit_base)
      ADDR_ENABLE_MAIN: bit_word = cur.enable_main;
      ADDR_PRIO_LOW_MAIN: bit_word = cur.prio_low_main;
      ADDR_ENABLE_AUX: bit_word = cur.enable_aux;
      ADDR_PRIO_LOW_AUX: bit_word = cur.prio_low_aux;
      default: bit_word = 8'h00;
    endcase
    next_cur.bit_rdata = bit_req_i.rd ? bit_word[bit_pos] : 1'b0;

    // in-service levels: a return retires the highest, an ack enters the offered one
    // return goes first so a same-cycle return and ack nest correctly
    svc = cur.in_service;
    if (irq_return_i && any_service) begin
      svc[service_level] = 1'b0;
    end
    if (irq_ack_i && cur.offer.req) begin
      svc[cur.offer.level] = 1'b1;
    end
    next_cur.in_service = svc;

    // offer stays live while arbitration still allows it; ack withdraws it for a cycle
    case (cur.fsm)
      ST_IDLE: begin
        if (may_offer) begin
          next_cur.fsm = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (irq_ack_i || !may_offer) begin
          next_cur.fsm = ST_IDLE;
        end
      end
      default: next_cur.fsm = ST_IDLE;
    endcase

    if (next_cur.fsm == ST_OFFER) begin
      next_cur.offer.req = 1'b1;
      next_cur.offer.level = win_level;
      next_cur.offer.vector = win_vector;
    end else begin
      next_cur.offer.req = 1'b0;
      next_cur.offer.level = 2'h0;
      next_cur.offer.vector = 16'h0000;
    end

    // wake needs no global enable: the core restarts and then arbitrates
    next_cur.wake = power_down_i && (|pending);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cur.enable_main <= REG_RESET;
      cur.prio_high_main <= REG_RESET;
      cur.prio_low_main <= REG_RESET;
      cur.enable_aux <= REG_RESET;
      cur.prio_high_aux <= REG_RESET;
      cur.prio_low_aux <= REG_RESET;
      // service state is not a software register but must start clear too
      cur.module_flags <= '0;
      cur.in_service <= '0;
      cur.fsm <= ST_IDLE;
      cur.offer <= '0;
      cur.wake <= 1'b0;
      cur.rdata <= 8'h00;
      cur.bit_rdata <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end


  // outputs are state fields, nothing sits after the flops
  assign rdata_o = cur.rdata;
  assign bit_rdata_o = cur.bit_rdata;
  assign offer_o = cur.offer;
  assign wake_o = cur.wake;

endmodule : irq_priority_unit

// [testbench/irq_core_model.sv]
// processor core stand-in: takes an offered vector while the bench allows it
// assumes offer_i is registered on the rising edge of clock_i
`timescale 1ns/1ps
module irq_core_model
  import irq_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // bench control
  input wire logic ack_en_i,
  // unit handshake
  input wire irq_offer_t offer_i,
  output logic ack_o,
  output logic [15:0] taken_o
);
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_o <= 1'b0;
      taken_o <= 16'h0000;
    end else begin
      // one pulse per offer; slow answers come from holding ack_en_i low
      ack_o <= ack_en_i & offer_i.req & ~ack_o;
      if (ack_o & offer_i.req) begin
        taken_o <= offer_i.vector;
      end
    end
  end
endmodule : irq_core_model

// [testbench/irq_priority_unit_asserts.sv]
// port-level checks of the interrupt priority unit
// assumes binding onto irq_priority_unit, one clock domain
`timescale 1ns/1ps
module irq_priority_unit_checker
  import irq_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire reg_req_t reg_req_i,
  input wire logic [7:0] rdata_o,
  input wire bit_req_t bit_req_i,
  input wire logic bit_rdata_o,
  input wire src_flags_t src_i,
  input wire logic power_down_i,
  input wire logic irq_ack_i,
  input wire logic irq_return_i,
  input wire irq_offer_t offer_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  property p_vec_set;
    offer_o.req |-> offer_o.vector inside {16'h0003, 16'h000B, 16'h0013,
      16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h004B};
  endproperty
  a_vec_set: assert property (p_vec_set) else $error("vector outside table");
  property p_serial;
    offer_o.req && offer_o.vector == 16'h0023 |-> $past(src_i.serial_tx_done_flag
      || src_i.serial_rx_done_flag || src_i.sync_serial_done_flag);
  endproperty
  a_serial: assert property (p_serial) else $error("serial vector without flag");
  property p_brownout;
    offer_o.req && offer_o.vector == 16'h004B |-> $past(src_i.brownout_detect);
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out vector bad");
  property p_timer0;
    offer_o.req && offer_o.vector == 16'h000B |-> $past(src_i.timer0_overflow_flag);
  endproperty
  a_timer0: assert property (p_timer0) else $error("timer0 vector bad");
  property p_ext1;
    offer_o.req && offer_o.vector == 16'h0013 |-> $past(src_i.ext1_request_flag);
  endproperty
  a_ext1: assert property (p_ext1) else $error("ext1 vector bad");
  property p_timer2;
    offer_o.req && offer_o.vector == 16'h002B |->
      $past(src_i.timer2_overflow_flag || src_i.timer2_external_flag);
  endproperty
  a_timer2: assert property (p_timer2) else $error("timer2 vector bad");
  property p_ack_drop;
    irq_ack_i && offer_o.req |=> !offer_o.req;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("offer kept after ack");
  property p_rdata_idle;
    !$past(reg_req_i.rd) |-> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_wake;
    wake_o |-> $past(power_down_i && ((src_i.ext0_request_flag && src_i.ext0_level_mode)
      || (src_i.ext1_request_flag && src_i.ext1_level_mode)));
  endproperty
  a_wake: assert property (p_wake) else $error("wake without level input");
  property p_pd_ext;
    offer_o.req && $past(power_down_i) |-> offer_o.vector inside {16'h0003, 16'h0013};
  endproperty
  a_pd_ext: assert property (p_pd_ext) else $error("non-external offer in power-down");
  c_ack: cover property (offer_o.req ##1 irq_ack_i);
  c_wake: cover property (wake_o);
  c_return: cover property (irq_return_i ##2 offer_o.req);
endmodule : irq_priority_unit_checker

bind irq_priority_unit irq_priority_unit_checker i_chk (
  .clock_i(clock_i), .srst_i(srst_i), .reg_req_i(reg_req_i), .rdata_o(rdata_o),
  .bit_req_i(bit_req_i), .bit_rdata_o(bit_rdata_o), .src_i(src_i),
  .power_down_i(power_down_i), .irq_ack_i(irq_ack_i), .irq_return_i(irq_return_i),
  .offer_o(offer_o), .wake_o(wake_o));

// [testbench/tb_top.sv]
// self-checking bench of the interrupt priority unit with a core stand-in
// assumes a 40 MHz clock and synchronous active-high reset
`timescale 1ns/1ps
module tb_top;
  import irq_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  reg_req_t rq = '0;
  bit_req_t bq = '0;
  src_flags_t src = '0;
  logic pd = 1'b0;
  logic ret = 1'b0;
  logic ack_en = 1'b0;
  logic ack;
  logic brd;
  logic wake;
  logic [7:0] rdata;
  logic [15:0] taken;
  irq_offer_t offer;
  int bad_count = 0;
  int checked = 0;
  logic [15:0] vec [8] = '{16'h0003, 16'h004B, 16'h000B, 16'h0013,
    16'h001B, 16'h0033, 16'h0023, 16'h002B};
  int pos [8] = '{0, 3, 1, 2, 3, 6, 4, 5};

  always #12.5 clock_i = ~clock_i;

  irq_priority_unit i_dut (
    .clock_i(clock_i), .srst_i(srst_i), .reg_req_i(rq), .rdata_o(rdata),
    .bit_req_i(bq), .bit_rdata_o(brd), .src_i(src), .power_down_i(pd),
    .irq_ack_i(ack), .irq_return_i(ret), .offer_o(offer), .wake_o(wake));
  irq_core_model i_core (
    .clock_i(clock_i), .srst_i(srst_i), .ack_en_i(ack_en), .offer_i(offer),
    .ack_o(ack), .taken_o(taken));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    rq <= '{1'b1, 1'b0, a, d};
    @(posedge clock_i);
    rq <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    rq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    rq <= '0;
    #1 chk({12'h000, rdata}, {12'h000, e});
  endtask : rd

  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge clock_i);
    bq <= '{1'b1, 1'b0, a, v};
    @(posedge clock_i);
    bq <= '0;
  endtask : bwr

  task automatic off(input logic r, input logic [1:0] l, input logic [15:0] v);
    cyc(2);
    #1 chk({1'b0, offer}, {1'b0, r, l, v});
  endtask : off

  function automatic src_flags_t flags(input logic [7:0] m);
    src_flags_t s;
    s = '0;
    s.ext0_request_flag = m[0];
    s.brownout_detect = m[1];
    s.timer0_overflow_flag = m[2];
    s.ext1_request_flag = m[3];
    s.timer1_overflow_flag = m[4];
    s.counter_array_overflow_flag = m[5];
    s.sync_serial_done_flag = m[6];
    s.timer2_overflow_flag = m[7];
    return s;
  endfunction : flags

  task automatic setsrc(input logic [7:0] m);
    @(posedge clock_i);
    src <= flags(m);
  endtask : setsrc

  task automatic t_regs;
    logic [7:0] a [7] = '{8'hA8, 8'hB7, 8'hB8, 8'hE8, 8'hF7, 8'hF8, 8'h80};
    logic [7:0] m [7] = '{8'hFF, 8'h7F, 8'h7F, 8'h08, 8'h10, 8'h10, 8'h00};
    for (int i = 0; i < 7; i++) rd(a[i], 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(a[i], 8'hFF);
      rd(a[i], m[i]);
      wr(a[i], 8'h00);
    end
    bwr(8'hFC, 1'b1);
    rd(8'hF8, 8'h10);
    bwr(8'hB7, 1'b1);
    rd(8'hB7, 8'h00);
    bwr(8'hAB, 1'b1);
    @(posedge clock_i);
    bq <= '{1'b0, 1'b1, 8'hAB, 1'b0};
    @(posedge clock_i);
    bq <= '0;
    #1 chk({19'h0, brd}, 20'h1);
    rd(8'hA8, 8'h08);
    wr(8'hA8, 8'h00);
    wr(8'hF8, 8'h00);
  endtask : t_regs

  task automatic t_vec;
    for (int i = 0; i < 8; i++) begin
      logic [7:0] e;
      e = (i == 1) ? 8'h00 : 8'h01 << pos[i];
      setsrc(8'h01 << i);
      if (i == 1) wr(8'hE8, 8'h08);
      wr(8'hA8, e);
      off(1'b0, 2'h0, 16'h0000);
      wr(8'hA8, 8'h80 | e);
      off(1'b1, 2'h0, vec[i]);
      wr(8'hE8, 8'h00);
    end
  endtask : t_vec

  task automatic t_poll;
    wr(8'hA8, 8'hFF);
    wr(8'hE8, 8'h08);
    for (int i = 0; i < 8; i++) begin
      setsrc(8'hFF << i);
      off(1'b1, 2'h0, vec[i]);
    end
    setsrc(8'hFF);
    wr(8'hB8, 8'h20);
    off(1'b1, 2'h1, vec[7]);
    wr(8'hB7, 8'h20);
    off(1'b1, 2'h3, vec[7]);
    wr(8'hF7, 8'h10);
    wr(8'hB7, 8'h00);
    wr(8'hB8, 8'h00);
    off(1'b1, 2'h2, vec[1]);
    wr(8'hF8, 8'h10);
    off(1'b1, 2'h3, vec[1]);
    wr(8'hF7, 8'h00);
    wr(8'hF8, 8'h00);
  endtask : t_poll

  task automatic t_pre;
    wr(8'hB8, 8'h02);
    setsrc(8'h04);
    off(1'b1, 2'h1, vec[2]);
    @(posedge clock_i);
    ack_en <= 1'b1;
    cyc(3);
    ack_en <= 1'b0;
    off(1'b0, 2'h0, 16'h0000);
    chk({4'h0, taken}, {4'h0, vec[2]});
    rd(8'hCA, 8'h25);
    wr(8'hB8, 8'h06);
    setsrc(8'h0C);
    off(1'b0, 2'h0, 16'h0000);
    wr(8'hB7, 8'h01);
    setsrc(8'h0D);
    off(1'b1, 2'h2, vec[0]);
    setsrc(8'h0C);
    @(posedge clock_i);
    ret <= 1'b1;
    @(posedge clock_i);
    ret <= 1'b0;
    off(1'b1, 2'h1, vec[2]);
    wr(8'hB7, 8'h00);
    wr(8'hB8, 8'h00);
  endtask : t_pre

  task automatic t_wake;
    wr(8'hA8, 8'h83);
    setsrc(8'h05);
    pd <= 1'b1;
    cyc(2);
    #1 chk({19'h0, wake}, 20'h0);
    off(1'b0, 2'h0, 16'h0000);
    @(posedge clock_i);
    src.ext0_level_mode <= 1'b1;
    cyc(2);
    #1 chk({19'h0, wake}, 20'h1);
    off(1'b1, 2'h0, vec[0]);
    @(posedge clock_i);
    pd <= 1'b0;
    src <= '0;
    cyc(2);
    #1 chk({19'h0, wake}, 20'h0);
  endtask : t_wake

  task automatic t_share;
    src_flags_t s [3];
    s = '{default: '0};
    s[0].serial_tx_done_flag = 1'b1;
    s[1].serial_rx_done_flag = 1'b1;
    s[2].timer2_external_flag = 1'b1;
    wr(8'hA8, 8'hB0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_i);
      src <= s[i];
      off(1'b1, 2'h0, vec[6 + i / 2]);
    end
    @(posedge clock_i);
    src <= '0;
  endtask : t_share

  task automatic t_flags;
    wr(8'hA8, 8'hC0);
    @(posedge clock_i);
    src.module_irq_enable <= 5'h04;
    @(posedge clock_i);
    src.match_capture_event <= 5'h04;
    @(posedge clock_i);
    src.match_capture_event <= 5'h00;
    cyc(4);
    rd(8'hC9, 8'h04);
    off(1'b1, 2'h0, vec[5]);
    wr(8'hC9, 8'h00);
    rd(8'hC9, 8'h00);
    off(1'b0, 2'h0, 16'h0000);
    @(posedge clock_i);
    rq <= '{1'b1, 1'b0, 8'hC9, 8'h00};
    src.match_capture_event <= 5'h01;
    @(posedge clock_i);
    rq <= '0;
    src.match_capture_event <= 5'h00;
    rd(8'hC9, 8'h01);
  endtask : t_flags

  task automatic results;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    cyc(12);
    srst_i <= 1'b0;
    t_regs;
    t_vec;
    t_poll;
    t_pre;
    t_wake;
    t_share;
    t_flags;
    results;
  end

  // the whole run needs well under two thousand cycles
  initial begin
    cyc(20000);
    bad_count++;
    results;
  end
endmodule : tb_top
